// ==== verilog/ict_timing_defs.svh ====
// timing constants for the instruction cycle timing sequencer
`ifndef ICT_TIMING_DEFS_SVH
`define ICT_TIMING_DEFS_SVH

// ****************************************************************
// shift and rotate base counts
// ****************************************************************
`define ICT_SHIFT_BW_CLK 8'h06
`define ICT_SHIFT_L_CLK 8'h08
`define ICT_SHIFT_MEM_CLK 8'h08

// ****************************************************************
// single operand counts
// ****************************************************************
`define ICT_SGL_REG_CLK 8'h04
`define ICT_SGL_REGL_CLK 8'h06
`define ICT_SGL_MEM_CLK 8'h08
`define ICT_SGL_MEML_CLK 8'h0c
`define ICT_TAS_MEM_CLK 8'h0e

// ****************************************************************
// effective address indirect cost and move long figures
// ****************************************************************
`define ICT_EA_IND_BW_CLK 8'h04
`define ICT_EA_IND_L_CLK 8'h08
`define ICT_MV_INDEX_CLK 8'h0e
`define ICT_MV_ABSL_CLK 8'h10
`define ICT_MOVL_RR_CLK 8'h04
`define ICT_MOVL_RI_CLK 8'h0c
`define ICT_MOVL_AA_CLK 8'h24
`define ICT_MOVL_XD_CLK 8'h12

`endif

// ==== verilog/ict_pkg.sv ====
// types shared by the instruction cycle timing sequencer
package ict_pkg;
    // ****************************************************************
    // operation classes
    // ****************************************************************
    typedef enum logic [3:0] {
        ICT_OP_SHIFT,
        ICT_OP_CLEAR,
        ICT_OP_NEGATE,
        ICT_OP_NEGATE_EXT,
        ICT_OP_INVERT,
        ICT_OP_DEC_NEGATE,
        ICT_OP_SET_COND,
        ICT_OP_TEST_SET,
        ICT_OP_TEST,
        ICT_OP_MOVE_LONG
    } ict_op_type;

    typedef enum logic [1:0] {
        ICT_SZ_BYTE,
        ICT_SZ_WORD,
        ICT_SZ_LONG
    } ict_size_type;

    // move long operand forms
    typedef enum logic [2:0] {
        ICT_MV_REG,
        ICT_MV_IND,
        ICT_MV_INDEX,
        ICT_MV_ABS_LONG
    } ict_mv_type;
endpackage

// ==== verilog/ict_bus_pacer.sv ====
// bus cycle pacer: spreads reads and writes over an instruction's clocks
`timescale 1ns/1ps
`default_nettype none
module ict_bus_pacer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // plan
    input wire logic load,
    input wire logic [7:0] totalClk,
    input wire logic [3:0] readCnt,
    input wire logic [3:0] writeCnt,
    // status
    output logic busy,
    output logic readStrobe,
    output logic writeStrobe,
    output logic done
);
    logic [7:0] clkLeft, next_clkLeft;
    logic [3:0] rdLeft, next_rdLeft;
    logic [3:0] wrLeft, next_wrLeft;
    logic next_busy, next_readStrobe, next_writeStrobe, next_done;

    // one bus cycle per four clocks, reads first, all within the total
    always_comb begin
        next_clkLeft = clkLeft;
        next_rdLeft = rdLeft;
        next_wrLeft = wrLeft;
        next_busy = busy;
        next_readStrobe = 1'b0;
        next_writeStrobe = 1'b0;
        next_done = 1'b0;
        if (load) begin
            next_clkLeft = totalClk;
            next_rdLeft = readCnt;
            next_wrLeft = writeCnt;
            next_busy = 1'b1;
        end else if (busy) begin
            next_clkLeft = clkLeft - 8'h01;
            if (clkLeft[1:0] == 2'h0 && rdLeft != 4'h0) begin
                next_rdLeft = rdLeft - 4'h1;
                next_readStrobe = 1'b1;
            end else if (clkLeft[1:0] == 2'h0 && wrLeft != 4'h0) begin
                next_wrLeft = wrLeft - 4'h1;
                next_writeStrobe = 1'b1;
            end
            if (clkLeft == 8'h01) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clkLeft <= 8'h00;
            rdLeft <= 4'h0;
            wrLeft <= 4'h0;
            busy <= 1'b0;
            readStrobe <= 1'b0;
            writeStrobe <= 1'b0;
            done <= 1'b0;
        end else begin
            clkLeft <= next_clkLeft;
            rdLeft <= next_rdLeft;
            wrLeft <= next_wrLeft;
            busy <= next_busy;
            readStrobe <= next_readStrobe;
            writeStrobe <= next_writeStrobe;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ict_sequencer.sv ====
// instruction cycle timing sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ict_timing_defs.svh"
module ict_sequencer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // instruction request
    input wire logic start,
    input wire ict_pkg::ict_op_type opClass,
    input wire ict_pkg::ict_size_type opSize,
    input wire logic memOperand,
    input wire logic condTrue,
    input wire logic countFromReg,
    input wire logic [2:0] countField,
    input wire logic [5:0] countReg,
    input wire ict_pkg::ict_mv_type moveSrc,
    input wire ict_pkg::ict_mv_type moveDst,
    input wire logic indexLong,
    // address calculation cost
    input wire logic [7:0] eaClk,
    input wire logic [3:0] eaReads,
    input wire logic [3:0] eaWrites,
    // status
    output logic busy,
    output logic busRead,
    output logic busWrite,
    output logic done,
    output logic illegalForm,
    output logic [7:0] cycleTotal
);
    import ict_pkg::*;

    typedef enum logic [1:0] {ICT_IDLE, ICT_LOAD, ICT_RUN} ict_state_type;

    ict_state_type state, next_state;
    logic [7:0] plannedClk, next_plannedClk;
    logic [3:0] plannedRd, next_plannedRd;
    logic [3:0] plannedWr, next_plannedWr;
    logic next_illegalForm;
    logic [7:0] next_cycleTotal;
    logic pacerLoad, pacerRead, pacerWrite, pacerDone;
    logic next_busy;
    logic [7:0] baseClk;
    logic [3:0] baseRd, baseWr;
    logic useEa, bad;
    logic [5:0] shiftN;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // long move cost of one operand side beyond register form
    function automatic logic [7:0] mv_side_clk(input ict_mv_type m);
        case (m)
            ICT_MV_REG: mv_side_clk = 8'h00;
            ICT_MV_IND: mv_side_clk = `ICT_EA_IND_L_CLK;
            ICT_MV_INDEX: mv_side_clk = `ICT_MV_INDEX_CLK;
            ICT_MV_ABS_LONG: mv_side_clk = `ICT_MV_ABSL_CLK;
            default: mv_side_clk = 8'h00;
        endcase
    endfunction

    function automatic logic [3:0] mv_side_rd(input ict_mv_type m);
        case (m)
            ICT_MV_REG: mv_side_rd = 4'h0;
            ICT_MV_IND: mv_side_rd = 4'h2;
            ICT_MV_INDEX: mv_side_rd = 4'h3;
            ICT_MV_ABS_LONG: mv_side_rd = 4'h4;
            default: mv_side_rd = 4'h0;
        endcase
    endfunction

    // ****************************************************************
    // base timing decode
    // ****************************************************************
    always_comb begin
        // immediate zero field means eight
        shiftN = countFromReg ? countReg : {2'h0, countField};
        if (!countFromReg && countField == 3'h0) begin
            shiftN = 6'h08;
        end
        baseClk = `ICT_SGL_REG_CLK;
        baseRd = 4'h1;
        baseWr = 4'h0;
        useEa = memOperand;
        bad = 1'b0;
        case (opClass)
            ICT_OP_SHIFT: begin
                if (memOperand) begin
                    baseClk = `ICT_SHIFT_MEM_CLK;
                    baseWr = 4'h1;
                    bad = (opSize != ICT_SZ_WORD);
                end else if (opSize == ICT_SZ_LONG) begin
                    baseClk = `ICT_SHIFT_L_CLK + {1'b0, shiftN, 1'b0};
                end else begin
                    baseClk = `ICT_SHIFT_BW_CLK + {1'b0, shiftN, 1'b0};
                end
            end
            ICT_OP_CLEAR, ICT_OP_NEGATE, ICT_OP_NEGATE_EXT, ICT_OP_INVERT: begin
                if (memOperand) begin
                    baseClk = (opSize == ICT_SZ_LONG) ? `ICT_SGL_MEML_CLK
                                                      : `ICT_SGL_MEM_CLK;
                    baseWr = (opSize == ICT_SZ_LONG) ? 4'h2 : 4'h1;
                end else begin
                    baseClk = (opSize == ICT_SZ_LONG) ? `ICT_SGL_REGL_CLK
                                                      : `ICT_SGL_REG_CLK;
                end
            end
            ICT_OP_DEC_NEGATE: begin
                baseClk = memOperand ? `ICT_SGL_MEM_CLK : `ICT_SGL_REGL_CLK;
                baseWr = memOperand ? 4'h1 : 4'h0;
            end
            ICT_OP_SET_COND: begin
                if (memOperand) begin
                    baseClk = `ICT_SGL_MEM_CLK;
                    baseWr = 4'h1;
                end else begin
                    baseClk = condTrue ? `ICT_SGL_REGL_CLK : `ICT_SGL_REG_CLK;
                end
            end
            ICT_OP_TEST_SET: begin
                baseClk = memOperand ? `ICT_TAS_MEM_CLK : `ICT_SGL_REG_CLK;
                baseRd = memOperand ? 4'h2 : 4'h1;
                baseWr = memOperand ? 4'h1 : 4'h0;
            end
            ICT_OP_TEST: begin
                baseClk = `ICT_SGL_REG_CLK;
            end
            ICT_OP_MOVE_LONG: begin
                // register form plus each memory side; index size unused
                useEa = 1'b0;
                baseClk = `ICT_MOVL_RR_CLK + mv_side_clk(moveSrc)
                          + mv_side_clk(moveDst);
                baseRd = 4'h1 + mv_side_rd(moveSrc) + mv_side_rd(moveDst);
                baseWr = (moveDst == ICT_MV_REG) ? 4'h0 : 4'h2;
                // a memory destination writes its two words instead of reading them
                if (moveDst != ICT_MV_REG) begin
                    baseRd = baseRd - 4'h2;
                end
            end
            default: bad = 1'b1;
        endcase
    end

    // ****************************************************************
    // sequencing state
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_plannedClk = plannedClk;
        next_plannedRd = plannedRd;
        next_plannedWr = plannedWr;
        next_illegalForm = 1'b0;
        next_cycleTotal = cycleTotal;
        next_busy = busy;
        pacerLoad = 1'b0;
        case (state)
            ICT_IDLE: begin
                if (start && bad) begin
                    next_illegalForm = 1'b1;
                end else if (start) begin
                    next_plannedClk = baseClk + (useEa ? eaClk : 8'h00);
                    next_plannedRd = baseRd + (useEa ? eaReads : 4'h0);
                    next_plannedWr = baseWr + (useEa ? eaWrites : 4'h0);
                    next_busy = 1'b1;
                    next_state = ICT_LOAD;
                end
            end
            ICT_LOAD: begin
                pacerLoad = 1'b1;
                next_cycleTotal = plannedClk;
                next_state = ICT_RUN;
            end
            ICT_RUN: begin
                if (pacerDone) begin
                    next_busy = 1'b0;
                    next_state = ICT_IDLE;
                end
            end
            default: next_state = ICT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ICT_IDLE;
            plannedClk <= 8'h00;
            plannedRd <= 4'h0;
            plannedWr <= 4'h0;
            illegalForm <= 1'b0;
            cycleTotal <= 8'h00;
            busy <= 1'b0;
            busRead <= 1'b0;
            busWrite <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            plannedClk <= next_plannedClk;
            plannedRd <= next_plannedRd;
            plannedWr <= next_plannedWr;
            illegalForm <= next_illegalForm;
            cycleTotal <= next_cycleTotal;
            busy <= next_busy;
            busRead <= pacerRead;
            busWrite <= pacerWrite;
            done <= pacerDone;
        end
    end

    // bus cycle spreading over the planned clocks
    ict_bus_pacer u_ict_bus_pacer (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(pacerLoad),
        .totalClk(plannedClk),
        .readCnt(plannedRd),
        .writeCnt(plannedWr),
        .busy(),
        .readStrobe(pacerRead),
        .writeStrobe(pacerWrite),
        .done(pacerDone)
    );
endmodule
`default_nettype wire

// ==== verif/ict_sequencer_chk.sv ====
// assertion checker for the instruction cycle timing sequencer
`timescale 1ns/1ps
`default_nettype none
module ict_sequencer_chk
    import ict_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // request
    input wire logic start,
    input wire ict_pkg::ict_op_type opClass,
    input wire ict_pkg::ict_size_type opSize,
    input wire logic memOperand,
    input wire logic countFromReg,
    input wire logic [2:0] countField,
    // status
    input wire logic busy,
    input wire logic busRead,
    input wire logic busWrite,
    input wire logic done,
    input wire logic illegalForm,
    input wire logic [7:0] cycleTotal
);
    // ****************************************************************
    // helper state and assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    ict_op_type opSeen;
    ict_op_type next_opSeen;

    // class of the last request made while not busy
    always_comb begin
        next_opSeen = opSeen;
        if (start && !busy) begin
            next_opSeen = opClass;
        end
    end

    // register the class
    always_ff @(posedge ref_clk) begin
        opSeen <= srst ? ICT_OP_SHIFT : next_opSeen;
    end

    busy_cause_a: assert property ($rose(busy) |-> $past(start))
        else $error("busy rose without a request");
    done_pulse_a: assert property (done |-> !busy ##1 !done)
        else $error("done not a lone pulse at the end");
    busy_end_a: assert property ($fell(busy) |-> done)
        else $error("busy dropped without done");
    strobe_gap_a: assert property ((busRead || busWrite) |=> !(busRead || busWrite))
        else $error("bus strobes back to back");
    strobe_busy_a: assert property ((busRead || busWrite) |-> $past(busy))
        else $error("bus strobe outside an instruction");
    illegal_form_a: assert property (illegalForm |-> !busy && $past(memOperand)
        && $past(opClass) == ICT_OP_SHIFT && $past(opSize) != ICT_SZ_WORD)
        else $error("illegal form flag without a memory shift of byte or long");
    done_bound_a: assert property ($rose(busy) |-> ##[3:270] done)
        else $error("instruction never finished");
    total_hold_a: assert property (busy && $past(busy) && $past(busy, 2) |-> $stable(cycleTotal))
        else $error("total changed in mid instruction");
    shift_total_a: assert property ($rose(busy) && $past(opClass) == ICT_OP_SHIFT
        && !$past(memOperand) && $past(opSize) != ICT_SZ_LONG && !$past(countFromReg)
        |=> cycleTotal == 8'h06 + {3'h0, (($past(countField, 2) == 3'h0) ? 4'h8
        : {1'b0, $past(countField, 2)}), 1'b0})
        else $error("short register shift total wrong");
    test_nowrite_a: assert property (busWrite |-> opSeen != ICT_OP_TEST)
        else $error("operand test wrote to the bus");
endmodule
`default_nettype wire

// ==== verif/ict_mem_model.sv ====
// bus cycle counting model of the memory beyond the sequencer
`timescale 1ns/1ps
`default_nettype none
module ict_mem_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // strobes and count restart
    input wire logic clear,
    input wire logic busRead,
    input wire logic busWrite,
    // served cycle counts
    output logic [7:0] readCount,
    output logic [7:0] writeCount
);
    // serve one bus cycle per strobe and tally it
    always_ff @(posedge ref_clk) begin
        if (srst || clear) begin
            readCount <= 8'h00;
            writeCount <= 8'h00;
        end else begin
            readCount <= readCount + {7'h00, busRead};
            writeCount <= writeCount + {7'h00, busWrite};
        end
    end
endmodule
`default_nettype wire

// ==== verif/instruction_cycle_timing_bench.sv ====
// self-checking bench for the instruction cycle timing sequencer
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_bench;
    import ict_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, start = 1'b0, memOperand = 1'b0, condTrue = 1'b0;
    logic countFromReg = 1'b0, indexLong = 1'b0, clearCnt = 1'b0;
    ict_op_type opClass = ICT_OP_SHIFT;
    ict_size_type opSize = ICT_SZ_WORD;
    ict_mv_type moveSrc = ICT_MV_REG, moveDst = ICT_MV_REG;
    logic [2:0] countField = 3'h0;
    logic [5:0] countReg = 6'h00;
    logic [7:0] eaClk = 8'h00, cycleTotal, readCount, writeCount;
    logic [3:0] eaReads = 4'h0, eaWrites = 4'h0;
    logic busy, busRead, busWrite, done, illegalForm;
    int err_count = 0, tests_run = 0, seed = 33853;

    // ****************************************************************
    // clock, design and memory model
    // ****************************************************************
    always #50 ref_clk = ~ref_clk;
    ict_sequencer u_ict_sequencer (.ref_clk(ref_clk), .srst(srst), .start(start),
        .opClass(opClass), .opSize(opSize), .memOperand(memOperand), .condTrue(condTrue),
        .countFromReg(countFromReg), .countField(countField), .countReg(countReg),
        .moveSrc(moveSrc), .moveDst(moveDst), .indexLong(indexLong), .eaClk(eaClk),
        .eaReads(eaReads), .eaWrites(eaWrites), .busy(busy), .busRead(busRead),
        .busWrite(busWrite), .done(done), .illegalForm(illegalForm), .cycleTotal(cycleTotal));
    ict_mem_model u_ict_mem_model (.ref_clk(ref_clk), .srst(srst), .clear(clearCnt),
        .busRead(busRead), .busWrite(busWrite), .readCount(readCount), .writeCount(writeCount));

    // ****************************************************************
    // checking, expectation and stimulus tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // clocks, reads and writes packed as 8/4/4 bits
    function automatic logic [15:0] expect_t(input ict_op_type op, input ict_size_type sz,
        input logic mem, input logic cnd, input logic [6:0] n);
        logic lng;
        lng = (sz == ICT_SZ_LONG);
        case (op)
            ICT_OP_SHIFT: return mem ? 16'h0811 : {(lng ? 8'h08 : 8'h06) + {n, 1'b0}, 8'h10};
            ICT_OP_CLEAR, ICT_OP_NEGATE, ICT_OP_NEGATE_EXT, ICT_OP_INVERT:
                return mem ? (lng ? 16'h0c12 : 16'h0811) : (lng ? 16'h0610 : 16'h0410);
            ICT_OP_DEC_NEGATE: return mem ? 16'h0811 : 16'h0610;
            ICT_OP_SET_COND: return mem ? 16'h0811 : (cnd ? 16'h0610 : 16'h0410);
            ICT_OP_TEST_SET: return mem ? 16'h0e21 : 16'h0410;
            default: return 16'h0410;
        endcase
    endfunction

    // one instruction; poke retries start while busy
    task automatic run_op(input logic [15:0] exp, input logic poke);
        int lat;
        lat = 0;
        start <= 1'b1;
        clearCnt <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        clearCnt <= 1'b0;
        while (done !== 1'b1 && lat < 400) begin
            @(negedge ref_clk);
            lat++;
            if (poke && lat == 4) begin
                @(posedge ref_clk);
                start <= 1'b1;
                @(posedge ref_clk);
                start <= 1'b0;
                lat++;
            end
        end
        check({8'h00, 8'(lat)}, {8'h00, exp[15:8] + 8'h03});
        check({8'h00, cycleTotal}, {8'h00, exp[15:8]});
        @(posedge ref_clk);
        @(posedge ref_clk);
        check({readCount, writeCount}, {4'h0, exp[7:4], 4'h0, exp[3:0]});
    endtask

    task automatic go(input ict_op_type op, input ict_size_type sz, input logic mem,
        input logic cnd, input logic fr, input logic [2:0] fld, input logic [5:0] rg,
        input logic poke);
        logic [6:0] n;
        logic [15:0] ea;
        logic [1:0] sel;
        sel = 2'($unsigned($random(seed)) % 3);
        ea = (sel == 2'h0) ? 16'h0000 : ((sel == 2'h1) ? 16'h0410 : 16'h0820);
        n = fr ? {1'b0, rg} : ((fld == 3'h0) ? 7'h08 : {4'h0, fld});
        {eaClk, eaReads, eaWrites} <= ea;
        opClass <= op;
        opSize <= sz;
        memOperand <= mem;
        condTrue <= cnd;
        countFromReg <= fr;
        countField <= fld;
        countReg <= rg;
        run_op(expect_t(op, sz, mem, cnd, n) + (mem ? ea : 16'h0000), poke);
    endtask

    task automatic mv(input ict_mv_type s, input ict_mv_type d, input logic ix,
        input logic [15:0] exp);
        opClass <= ICT_OP_MOVE_LONG;
        memOperand <= 1'b0;
        moveSrc <= s;
        moveDst <= d;
        indexLong <= ix;
        run_op(exp, 1'b0);
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        ict_op_type op;
        ict_size_type sz;
        logic m;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            go(ICT_OP_SHIFT, ICT_SZ_WORD, 1'b0, 1'b0, 1'b0, 3'(i), 6'h00, i == 0);
        end
        go(ICT_OP_SHIFT, ICT_SZ_LONG, 1'b0, 1'b0, 1'b1, 3'h0, 6'h3f, 1'b0);
        go(ICT_OP_SHIFT, ICT_SZ_BYTE, 1'b0, 1'b0, 1'b1, 3'h0, 6'h00, 1'b0);
        go(ICT_OP_SHIFT, ICT_SZ_WORD, 1'b1, 1'b0, 1'b0, 3'h3, 6'h00, 1'b0);
        for (int k = 1; k < 9; k++) begin
            go(ict_op_type'(k), ICT_SZ_BYTE, k[0], k[1], 1'b0, 3'h1, 6'h00, 1'b0);
            go(ict_op_type'(k), ICT_SZ_BYTE, !k[0], !k[1], 1'b0, 3'h1, 6'h00, 1'b0);
        end
        mv(ICT_MV_REG, ICT_MV_REG, 1'b0, 16'h0410);
        mv(ICT_MV_REG, ICT_MV_IND, 1'b0, 16'h0c12);
        mv(ICT_MV_ABS_LONG, ICT_MV_ABS_LONG, 1'b0, 16'h2472);
        mv(ICT_MV_INDEX, ICT_MV_REG, 1'b0, 16'h1240);
        mv(ICT_MV_INDEX, ICT_MV_REG, 1'b1, 16'h1240);
        for (int i = 0; i < 40; i++) begin
            op = ict_op_type'($unsigned($random(seed)) % 9);
            sz = ict_size_type'($unsigned($random(seed)) % 3);
            m = 1'($random(seed));
            if (op inside {ICT_OP_DEC_NEGATE, ICT_OP_SET_COND, ICT_OP_TEST_SET}) begin
                sz = ICT_SZ_BYTE;
            end
            // memory shifts exist for words only; others are refused
            if (op == ICT_OP_SHIFT && m) begin
                sz = ICT_SZ_WORD;
            end
            go(op, sz, m, 1'($random(seed)), 1'($random(seed)), 3'($random(seed)),
                6'($random(seed)), 1'b0);
        end
        opClass <= ICT_OP_SHIFT;
        opSize <= ICT_SZ_BYTE;
        memOperand <= 1'b1;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        @(negedge ref_clk);
        check({14'h0000, busy, illegalForm}, 16'h0001);
        complete_run();
    end

    // cut a hang short
    initial begin
        repeat (30000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end
endmodule

bind ict_sequencer ict_sequencer_chk u_ict_sequencer_chk (.ref_clk(ref_clk), .srst(srst),
    .start(start), .opClass(opClass), .opSize(opSize), .memOperand(memOperand),
    .countFromReg(countFromReg), .countField(countField), .busy(busy), .busRead(busRead),
    .busWrite(busWrite), .done(done), .illegalForm(illegalForm), .cycleTotal(cycleTotal));
`default_nettype wire
